// ===== src/gcd_regs.vh
// register offsets, field positions and reset values of the port c / port d block
`ifndef GCD_REGS_VH
`define GCD_REGS_VH

// register addresses on the plain register port
`define GCD_ADDR_PORT_C_DATA     8'h02
`define GCD_ADDR_PORT_D_DATA     8'h03
`define GCD_ADDR_PORT_C_DIR      8'h06
`define GCD_ADDR_PORT_D_DIR      8'h07

// widths of the two ports
`define GCD_PORT_C_PINS          5
`define GCD_PORT_D_PINS          7

// field positions
`define GCD_CLK_OUT_EN_BIT       7
`define GCD_CLK_OUT_PIN          2
`define GCD_TIMER_CLK_PIN        6

// reset values of the direction registers
`define GCD_PORT_C_DIR_RST       5'h00
`define GCD_CLK_OUT_EN_RST       1'h0
`define GCD_PORT_D_DIR_RST       7'h00

// converter channel number of port d pin zero
`define GCD_FIRST_D_CHANNEL      5'h08

// prescaler code that picks the external timer clock pin
`define GCD_TIMER_EXT_CLK_SEL    3'h7

`endif

// ===== src/gcd_ports.v
// general-purpose port c (with bus clock out) and port d (shared with converter and timer)
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
//
// Functional notes
// RL1 - port c direction one enables pin driver
// RL2 - clock-out enable drives bus clock on pin two
// RL3 - clock-out enable overrides pin two direction
// RL4 - reset clears clock-out enable bit
// RL5 - reset clears all port c direction bits
// RL6 - software loads data before setting direction
// RL7 - port c output bits read the latch
// RL8 - port c input bits read the pin
// RL9 - data writes always update the latch
// RL10 - clock-out pin two reads latch, writes inert
// RL11 - port d holds seven latches, bits six..zero
// RL12 - channel select makes port d pin analog
// RL13 - analog pin reads zero or latch by direction
// RL14 - analog pin stays input whatever direction says
// RL15 - prescaler may pick pin six as timer clock
// RL16 - software avoids channel fourteen with timer clock
// RL17 - port d direction one enables pin driver
// RL18 - reset clears all port d direction bits
// RL19 - digital port d pin reads latch or pin
// RL20 - software loads port d data before direction
// RL21 - bus clock out only while enable set
// RL22 - reset leaves data latches unchanged
// RL23 - unimplemented bits read zero, ignore writes

`include "gcd_regs.vh"

module gcd_ports #(
   parameter [7:0] ADDR_C_DATA = `GCD_ADDR_PORT_C_DATA,
   parameter [7:0] ADDR_D_DATA = `GCD_ADDR_PORT_D_DATA,
   parameter [7:0] ADDR_C_DIR  = `GCD_ADDR_PORT_C_DIR,
   parameter [7:0] ADDR_D_DIR  = `GCD_ADDR_PORT_D_DIR,
   parameter [2:0] TIMER_SEL   = `GCD_TIMER_EXT_CLK_SEL
) (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire [7:0]  addr_i,
   input  wire [7:0]  wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [7:0]  rdata_o,
   input  wire [4:0]  port_c_pin_i,
   output wire [4:0]  port_c_pin_o,
   output wire [4:0]  port_c_pin_oe_o,
   input  wire [6:0]  port_d_pin_i,
   output wire [6:0]  port_d_pin_o,
   output wire [6:0]  port_d_pin_oe_o,
   input  wire [4:0]  converter_channel_select_i,
   input  wire [2:0]  timer_prescaler_select_i,
   output wire        external_timer_clock_in_o,
   output wire        bus_clock_out_enable_o
);

   // true when the converter has picked channel ch; integer channel avoids a genvar part-select
   function chan_hit;
      input [4:0]   sel;
      input integer ch;
      begin
         chan_hit = ({27'h0000000, sel} == ch);
      end
   endfunction

   reg  [4:0] port_c_data_latch;
   reg  [6:0] port_d_data_latch;
   reg  [4:0] port_c_direction_bits;
   reg        bus_clock_out_enable;
   reg  [6:0] port_d_direction_bits;
   reg  [4:0] c_meta;
   reg  [4:0] c_sync;
   reg  [6:0] d_meta;
   reg  [6:0] d_sync;
   wire [6:0] d_adc_use;
   wire [6:0] d_read;
   wire [4:0] c_read;
   wire       timer_pin_sel;
   reg  [7:0] next_rdata;

   // two-stage synchronisers on the pin levels; only the second stage is read
   always @(posedge clk_i) begin
      c_meta <= port_c_pin_i;
      c_sync <= c_meta;
      d_meta <= port_d_pin_i;
      d_sync <= d_meta;
   end

   // data latches: no reset, so contents survive a system reset
   always @(posedge clk_i) begin
      if (wr_i && addr_i == ADDR_C_DATA) begin
         port_c_data_latch <= wdata_i[4:0]; // RL9
      end
      if (wr_i && addr_i == ADDR_D_DATA) begin
         port_d_data_latch <= wdata_i[6:0]; // RL11
      end
   end // RL22

   // direction registers and clock-out enable; bits not held here drop writes
   always @(posedge clk_i) begin
      if (rst_i) begin
         port_c_direction_bits <= `GCD_PORT_C_DIR_RST; // RL5
         bus_clock_out_enable  <= `GCD_CLK_OUT_EN_RST; // RL4
         port_d_direction_bits <= `GCD_PORT_D_DIR_RST; // RL18
      end else if (wr_i) begin
         if (addr_i == ADDR_C_DIR) begin
            port_c_direction_bits <= wdata_i[4:0];
            bus_clock_out_enable  <= wdata_i[`GCD_CLK_OUT_EN_BIT]; // RL21
         end
         if (addr_i == ADDR_D_DIR) begin
            port_d_direction_bits <= wdata_i[6:0]; // RL23
         end
      end
   end

   // port c pins; pin two hands over to the bus clock when enabled
   genvar i;
   generate
      for (i = 0; i < `GCD_PORT_C_PINS; i = i + 1) begin : g_pc
         if (i == `GCD_CLK_OUT_PIN) begin : g_clk
            // the raw clock leaves through a gate: pad timing is the user's hazard
            assign port_c_pin_oe_o[i] = bus_clock_out_enable | port_c_direction_bits[i]; // RL3
            assign port_c_pin_o[i]    = bus_clock_out_enable ? clk_i :
                                        (port_c_direction_bits[i] & port_c_data_latch[i]); // RL2
            // enabled clock output reads back the latch, writes never reach the pin
            assign c_read[i] = (bus_clock_out_enable | port_c_direction_bits[i]) ?
                               port_c_data_latch[i] : c_sync[i]; // RL10
         end else begin : g_io
            assign port_c_pin_oe_o[i] = port_c_direction_bits[i]; // RL1
            // gated so the pad sees zero while the unreset latch is unknown
            assign port_c_pin_o[i]    = port_c_direction_bits[i] & port_c_data_latch[i];
            assign c_read[i] = port_c_direction_bits[i] ? port_c_data_latch[i] : c_sync[i]; // RL7 RL8
         end
      end
   endgenerate

   // timer clock pick on pin six
   assign timer_pin_sel             = (timer_prescaler_select_i == TIMER_SEL); // RL15
   assign external_timer_clock_in_o = timer_pin_sel & d_sync[`GCD_TIMER_CLK_PIN];
   assign bus_clock_out_enable_o    = bus_clock_out_enable;

   // port d pins; a converter pick floats the pin and masks pin reads
   generate
      for (i = 0; i < `GCD_PORT_D_PINS; i = i + 1) begin : g_pd
         assign d_adc_use[i] = chan_hit(converter_channel_select_i,
                                        `GCD_FIRST_D_CHANNEL + i); // RL12
         if (i == `GCD_TIMER_CLK_PIN) begin : g_external_timer_clock_in
            // timer clock use holds the pin as an input
            assign port_d_pin_oe_o[i] = port_d_direction_bits[i] & ~d_adc_use[i] &
                                        ~timer_pin_sel; // RL14 RL15
         end else begin : g_io
            assign port_d_pin_oe_o[i] = port_d_direction_bits[i] & ~d_adc_use[i]; // RL17 RL14
         end
         assign port_d_pin_o[i] = port_d_pin_oe_o[i] & port_d_data_latch[i];
         assign d_read[i] = port_d_direction_bits[i] ? port_d_data_latch[i] :
                            (d_adc_use[i] ? 1'b0 : d_sync[i]); // RL13 RL19
      end
   endgenerate

   // read decode; unmapped addresses and unused bits give zero
   always @* begin
      next_rdata = 8'h00;
      case (addr_i)
         ADDR_C_DATA: next_rdata = {3'h0, c_read};
         ADDR_D_DATA: next_rdata = {1'h0, d_read}; // RL23
         ADDR_C_DIR:  next_rdata = {bus_clock_out_enable, 2'h0, port_c_direction_bits};
         ADDR_D_DIR:  next_rdata = {1'h0, port_d_direction_bits};
         default:     next_rdata = 8'h00;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         rdata_o <= next_rdata;
      end else begin
         rdata_o <= 8'h00;
      end
   end

endmodule // gcd_ports

// ===== test/gcd_pin_model.sv
// pins outside the block: driven level or outside level
`timescale 1ns/100ps
module gcd_pin_model #(parameter int W = 5) (
   input  wire logic [W-1:0] oe_i,
   input  wire logic [W-1:0] drv_i,
   input  wire logic [W-1:0] ext_i,
   output wire logic [W-1:0] lvl_o
);
   // a driven pin shows the block's value, an undriven one the outside level
   assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule // gcd_pin_model

// ===== test/gcd_ports_asserts.sv
// checker of the port c / port d block
`timescale 1ns/100ps
module gcd_ports_chk (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic [4:0] port_c_pin_oe_o,
   input wire logic [6:0] port_d_pin_o,
   input wire logic [6:0] port_d_pin_oe_o,
   input wire logic [4:0] converter_channel_select_i,
   input wire logic [2:0] timer_prescaler_select_i,
   input wire logic       bus_clock_out_enable_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // no read taken one cycle back means an idle data bus
   sequence s_idle; !rd_i ##1 1'b1; endsequence
   property p_c_rst; $past(rst_i) |-> port_c_pin_oe_o == 5'h00; endproperty
   a_c_rst: assert property (p_c_rst) else $error("port c driven after reset");
   property p_d_rst; $past(rst_i) |-> port_d_pin_oe_o == 7'h00; endproperty
   a_d_rst: assert property (p_d_rst) else $error("port d driven after reset");
   property p_en_rst; $past(rst_i) |-> !bus_clock_out_enable_o; endproperty
   a_en_rst: assert property (p_en_rst) else $error("clock out on after reset");
   property p_ck; bus_clock_out_enable_o |-> port_c_pin_oe_o[2]; endproperty
   a_ck: assert property (p_ck) else $error("clock pin not driven");
   property p_ana;
      converter_channel_select_i inside {[5'h08:5'h0E]} |->
         !port_d_pin_oe_o[converter_channel_select_i - 5'h08];
   endproperty
   a_ana: assert property (p_ana) else $error("analog pin driven");
   property p_tmr; timer_prescaler_select_i == 3'h7 |-> !port_d_pin_oe_o[6]; endproperty
   a_tmr: assert property (p_tmr) else $error("timer clock pin driven");
   property p_d_out; (port_d_pin_o & ~port_d_pin_oe_o) == 7'h00; endproperty
   a_d_out: assert property (p_d_out) else $error("undriven pin carries value");
   property p_rd; s_idle |-> rdata_o == 8'h00; endproperty
   a_rd: assert property (p_rd) else $error("read data outside read slot");
endmodule // gcd_ports_chk
bind gcd_ports gcd_ports_chk gcd_ports_chk_inst (.*);

// ===== test/tb_gcd_ports.sv
// self-checking bench of the port c / port d block
`timescale 1ns/100ps
module tb_gcd_ports;
   logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, external_timer_clock_in_o, bus_clock_out_enable_o;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
   logic [4:0] c_ext = 5'h15, port_c_pin_i, port_c_pin_o, port_c_pin_oe_o, converter_channel_select_i = 5'h00;
   logic [6:0] d_ext = 7'h55, port_d_pin_i, port_d_pin_o, port_d_pin_oe_o;
   logic [2:0] timer_prescaler_select_i = 3'h0;
   int fails = 0, checks_done = 0, cyc = 0;
   always #2.5 clk_i = ~clk_i;
   gcd_ports gcd_ports_inst (.*);
   gcd_pin_model #(.W(5)) gcd_pin_model_inst (.oe_i(port_c_pin_oe_o), .drv_i(port_c_pin_o), .ext_i(c_ext),
      .lvl_o(port_c_pin_i));
   gcd_pin_model #(.W(7)) gcd_pin_model_d_inst (.oe_i(port_d_pin_oe_o), .drv_i(port_d_pin_o), .ext_i(d_ext),
      .lvl_o(port_d_pin_i));
   task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(logic [7:0] a, logic [7:0] exp, string nm);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(nm, exp, rdata_o);
   endtask
   task automatic t_c();
      rd(8'h06, 8'h00, "c dir");
      chk("clk en", 8'h00, {7'h00, bus_clock_out_enable_o});
      wr(8'h02, 8'h0A);
      wr(8'h06, 8'h03);
      rd(8'h02, 8'h16, "c data");
      chk("c oe", 8'h03, {3'h0, port_c_pin_oe_o});
      chk("c out", 8'h02, {3'h0, port_c_pin_o});
      wr(8'h06, 8'hE0);
      rd(8'h06, 8'h80, "c dir");
      chk("c oe clk", 8'h04, {3'h0, port_c_pin_oe_o});
      rd(8'h02, 8'h11, "c data clk");
      wr(8'h06, 8'h00);
      #1 chk("c oe off", 8'h00, {3'h0, port_c_pin_oe_o});
      $display("test port c done");
   endtask
   task automatic t_d();
      rd(8'h07, 8'h00, "d dir");
      @(posedge clk_i);
      timer_prescaler_select_i <= 3'h7;
      converter_channel_select_i <= 5'h09;
      wr(8'h03, 8'hFF);
      wr(8'h07, 8'h8F);
      rd(8'h07, 8'h0F, "d dir");
      rd(8'h03, 8'h5F, "d data");
      chk("d oe", 8'h0D, {1'b0, port_d_pin_oe_o});
      chk("d out", 8'h0D, {1'b0, port_d_pin_o});
      chk("external_timer_clock_in", 8'h01, {7'h00, external_timer_clock_in_o});
      @(posedge clk_i);
      converter_channel_select_i <= 5'h0C;
      rd(8'h03, 8'h4F, "d analog");
      $display("test port d done");
   endtask
   task automatic t_rst();
      @(posedge clk_i);
      rst_i <= 1'b1;
      converter_channel_select_i <= 5'h00;
      timer_prescaler_select_i <= 3'h0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wr(8'h07, 8'h7F);
      rd(8'h03, 8'h7F, "latch kept");
      rd(8'h10, 8'h00, "unmapped");
      $display("test reset done");
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // cut a hang short well past the expected run
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_c();
      t_d();
      t_rst();
      wrap_up();
   end
endmodule // tb_gcd_ports
